// ===== hw/fmcsr_pkg.sv
// Constants for the fan monitor configuration and status register bank.
// Assumes a 100 MHz system clock; shared by the bank and its testbench.
package fmcsr_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] ADDR_PWM_ONE_CEIL   = 8'h38;
  localparam logic [7:0] ADDR_PWM_TWO_CEIL   = 8'h39;
  localparam logic [7:0] ADDR_PWM_THREE_CEIL = 8'h3A;
  localparam logic [7:0] ADDR_MAIN_CFG       = 8'h40;
  localparam logic [7:0] ADDR_PRIMARY_ALARM  = 8'h41;
  localparam logic [7:0] ADDR_SECONDARY_ALARM = 8'h42;

  // ==========================================================
  // Reset values
  localparam logic [7:0] CEIL_RESET   = 8'hFF;
  localparam logic [7:0] CFG_RESET    = 8'h01;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] READ_NONE    = 8'h00;
  localparam logic [7:0] DUTY_OFF     = 8'h00;

  // ==========================================================
  // Main configuration fields
  localparam int CFG_RUN_BIT     = 0;
  localparam int CFG_LOCK_BIT    = 1;
  localparam int CFG_READY_BIT   = 2;
  localparam int CFG_FULL_BIT    = 3;
  localparam int CFG_POWER_BIT   = 4;
  localparam int CFG_BYPASS_BIT  = 5;
  localparam int CFG_TIMEOUT_BIT = 6;
  localparam int CFG_VCC5_BIT    = 7;

  // ==========================================================
  // Status fields
  localparam int ALARM_COUNT = 5;
  localparam int FIRST_TEMP_CHANNEL = 2;
  localparam int ST1_BIT [ALARM_COUNT] = '{1, 2, 4, 5, 6};
  localparam int ST1_ANY_BIT  = 7;
  localparam int ST2_OVT_BIT  = 1;
  localparam int ST2_FAN_BIT  = 2;
  localparam int ST2_F4P_BIT  = 5;
  localparam int ST2_DIODE_BIT = 6;

  // ==========================================================
  // Shared pin modes and timing
  localparam logic [1:0] PIN_MODE_FAN4  = 2'h0;
  localparam logic [1:0] PIN_MODE_GPIO  = 2'h1;
  localparam logic [1:0] PIN_MODE_TIMER = 2'h2;
  localparam int PWM_COUNT       = 3;
  localparam int FAN_COUNT       = 4;
  localparam int CLOCK_PERIOD_NS = 10;
  localparam int READY_TIME_NS   = 1000;
  localparam int READY_CYCLES    =
    (READY_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

endpackage

// ===== hw/fmcsr_flag.sv
// One sticky alarm flag with clear-on-read once its condition has gone.
// Assumes value and limits come from same-clock measurement logic.
`timescale 1ns/10ps
`default_nettype none
module fmcsr_flag #(
  parameter bit USE_LIMITS = 1'b1,
  parameter bit SIGNED_CMP = 1'b0
) (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       reset,
  // Limit comparison
  input  wire logic [7:0] value,
  input  wire logic [7:0] high_limit,
  input  wire logic [7:0] low_limit,
  // Direct condition when limits are not used
  input  wire logic       set_event,
  input  wire logic       still_active,
  // Register read strobe and flag
  input  wire logic       read_clear,
  output logic            flag
);

  // ==========================================================
  // Limit comparison
  wire over_high = SIGNED_CMP ? ($signed(value) > $signed(high_limit))
                              : (value > high_limit);
  wire at_or_low = SIGNED_CMP ? ($signed(value) <= $signed(low_limit))
                              : (value <= low_limit);
  wire limit_hit = over_high | at_or_low;
  wire set_now   = USE_LIMITS ? limit_hit : set_event;
  wire active    = USE_LIMITS ? limit_hit : still_active;
  // Set beats a clearing read in the same cycle
  wire next_flag = set_now | (flag & ~(read_clear & ~active));

  always_ff @(posedge clock) begin
    if (reset) begin
      flag <= 1'b0;
    end else begin
      flag <= next_flag;
    end
  end

  // ==========================================================
  // Checks
  property p_flag_holds;
    @(posedge clock) disable iff (reset)
      (flag && active) |=> flag;
  endproperty
  a_flag_holds: assert property (p_flag_holds)
    else $error("alarm flag dropped while condition active");

  property p_flag_clears;
    @(posedge clock) disable iff (reset)
      (flag && read_clear && !active && !set_now) |=> !flag;
  endproperty
  a_flag_clears: assert property (p_flag_clears)
    else $error("alarm flag kept after read with condition gone");

endmodule
`default_nettype wire

// ===== hw/fmcsr_regs.sv
// Fan monitor configuration and status register bank: duty ceilings,
// main configuration, lock, ready, and two alarm status registers.
// Assumes a decoded serial register port and same-clock measurement
// logic supplying values, limits, stall and fault levels.
//
// Behaviour
// - Three 8-bit duty ceilings reset to full scale; duty never exceeds them while run is set.
// - Once locked, lockable registers including ceilings ignore all writes.
// - Run bit set uses programmed ceilings; clear uses power-up defaults.
// - Clearing run leaves stored ceiling values untouched.
// - After lock is written, run bit can no longer change.
// - Lock bit is write-once and holds until power cycling.
// - Ready bit is read-only, set by the device after power-up.
// - Full-speed bit forces all duties to the active ceiling, resets 0, never locks.
// - Power display flag is lockable software read/write storage.
// - Spin-up bypass bit is only stored and driven out as spinup_bypass, resets 0, never locks.
// - Lockable bit 6 enables the serial bus timeout feature.
// - Lockable bit 7 selects 5 V supply scaling, else 3.3 V.
// - First status flags rail and temperature limit violations.
// - First status flags clear on read only if condition has gone.
// - First status bit 7 is OR of all second status bits.
// - Overheat flag sets on overtemp, clears on read below hysteresis.
// - Fan 1-3 flags set on stall, never while that PWM is off.
// - Fan 4 flag set on stall, never while third PWM is off.
// - In GPIO mode status bit 5 is writable and drives the pin.
// - In timer mode bit 5 sets when overtemp time exceeds limit.
// - Bits 6 and 7 flag faults on remote diodes one and two.
// - High limit trips on greater than; low limit on less or equal.
`timescale 1ns/10ps
`default_nettype none
module fmcsr_regs
  import fmcsr_pkg::*;
#(
  parameter int READY_DELAY = READY_CYCLES
) (
  // Clock and reset
  input  wire logic                         clock,
  input  wire logic                         reset,
  // Register port from the serial interface
  input  wire logic [7:0]                   reg_addr,
  input  wire logic                         reg_write,
  input  wire logic [7:0]                   reg_wdata,
  input  wire logic                         reg_read,
  output logic      [7:0]                   reg_rdata,
  // Measured values and limits: cpu rail, vcc, remote1, local, remote2
  input  wire logic [ALARM_COUNT-1:0][7:0]  monitor_value,
  input  wire logic [ALARM_COUNT-1:0][7:0]  monitor_high,
  input  wire logic [ALARM_COUNT-1:0][7:0]  monitor_low,
  // Overtemperature and fan conditions
  input  wire logic                         overtemp_signal,
  input  wire logic                         overtemp_hysteresis,
  input  wire logic [FAN_COUNT-1:0]         fan_stall,
  input  wire logic [1:0]                   diode_fault,
  // Shared pin mode and overtemp timer
  input  wire logic [1:0]                   shared_pin_mode,
  input  wire logic [7:0]                   overtemp_time,
  input  wire logic [7:0]                   overtemp_time_limit,
  // Duty requests from the fan control loop
  input  wire logic [PWM_COUNT-1:0][7:0]    pwm_duty_request,
  // Duty outputs and configuration levels
  output logic      [PWM_COUNT-1:0][7:0]    pwm_duty,
  output logic                              monitor_run,
  output logic                              config_locked,
  output logic                              device_ready,
  output logic                              full_fan_override,
  output logic                              power_display_flag,
  output logic                              spinup_bypass,
  output logic                              bus_timeout_enable,
  output logic                              vcc_five_volt_scale,
  output logic                              gpio_level
);

  // ==========================================================
  // Parameter checks
  if (READY_DELAY < 1) begin : g_bad_ready
    $error("READY_DELAY must be at least one cycle");
  end

  localparam int READY_W = $clog2(READY_DELAY + 1);
  localparam logic [READY_W-1:0] READY_LAST =
    READY_W'(READY_DELAY - 1);

  // ==========================================================
  // Storage
  logic [PWM_COUNT-1:0][7:0] duty_ceiling;
  logic [READY_W-1:0]        ready_count;
  logic [ALARM_COUNT-1:0]    rail_flag;
  logic                      overheat_flag;
  logic [2:0]                fan_flag;
  logic                      fan_four_flag;
  logic [1:0]                diode_flag;

  // ==========================================================
  // Access decode
  wire wr_ceil_one   = reg_write && (reg_addr == ADDR_PWM_ONE_CEIL);
  wire wr_ceil_two   = reg_write && (reg_addr == ADDR_PWM_TWO_CEIL);
  wire wr_ceil_three = reg_write && (reg_addr == ADDR_PWM_THREE_CEIL);
  wire wr_cfg        = reg_write && (reg_addr == ADDR_MAIN_CFG);
  wire wr_secondary  = reg_write && (reg_addr == ADDR_SECONDARY_ALARM);
  wire rd_primary    = reg_read && (reg_addr == ADDR_PRIMARY_ALARM);
  wire rd_secondary  = reg_read && (reg_addr == ADDR_SECONDARY_ALARM);
  wire [PWM_COUNT-1:0] wr_ceil = {wr_ceil_three, wr_ceil_two,
                                  wr_ceil_one};
  // Lockable fields are writable only while the lock is open
  wire open_write    = !config_locked;
  wire gpio_mode     = (shared_pin_mode == PIN_MODE_GPIO);
  wire timer_mode    = (shared_pin_mode == PIN_MODE_TIMER);

  // ==========================================================
  // Duty ceilings
  always_ff @(posedge clock) begin
    if (reset) begin
      duty_ceiling <= {PWM_COUNT{CEIL_RESET}};
    end else begin
      for (int i = 0; i < PWM_COUNT; i++) begin
        if (wr_ceil[i] && open_write) begin
          duty_ceiling[i] <= reg_wdata;
        end
      end
    end
  end

  // Stored ceilings stay intact; the run bit only picks which applies
  wire [PWM_COUNT-1:0][7:0] active_ceiling =
    monitor_run ? duty_ceiling : {PWM_COUNT{CEIL_RESET}};

  // Full speed is taken as the ceiling, so the clamp is never broken
  logic [PWM_COUNT-1:0][7:0] next_duty;
  always_comb begin
    for (int i = 0; i < PWM_COUNT; i++) begin
      if (full_fan_override) begin
        next_duty[i] = active_ceiling[i];
      end else if (pwm_duty_request[i] > active_ceiling[i]) begin
        next_duty[i] = active_ceiling[i];
      end else begin
        next_duty[i] = pwm_duty_request[i];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      pwm_duty <= {PWM_COUNT{DUTY_OFF}};
    end else begin
      pwm_duty <= next_duty;
    end
  end

  // ==========================================================
  // Main configuration
  always_ff @(posedge clock) begin
    if (reset) begin
      monitor_run         <= CFG_RESET[CFG_RUN_BIT];
      config_locked       <= CFG_RESET[CFG_LOCK_BIT];
      full_fan_override   <= CFG_RESET[CFG_FULL_BIT];
      power_display_flag  <= CFG_RESET[CFG_POWER_BIT];
      spinup_bypass       <= CFG_RESET[CFG_BYPASS_BIT];
      bus_timeout_enable  <= CFG_RESET[CFG_TIMEOUT_BIT];
      vcc_five_volt_scale <= CFG_RESET[CFG_VCC5_BIT];
    end else if (wr_cfg) begin
      full_fan_override <= reg_wdata[CFG_FULL_BIT];
      spinup_bypass     <= reg_wdata[CFG_BYPASS_BIT];
      if (open_write) begin
        monitor_run         <= reg_wdata[CFG_RUN_BIT];
        config_locked       <= reg_wdata[CFG_LOCK_BIT];
        power_display_flag  <= reg_wdata[CFG_POWER_BIT];
        bus_timeout_enable  <= reg_wdata[CFG_TIMEOUT_BIT];
        vcc_five_volt_scale <= reg_wdata[CFG_VCC5_BIT];
      end
    end
  end

  // Ready rises a fixed time after reset; software cannot touch it
  always_ff @(posedge clock) begin
    if (reset) begin
      ready_count  <= '0;
      device_ready <= 1'b0;
    end else if (!device_ready) begin
      if (ready_count == READY_LAST) begin
        device_ready <= 1'b1;
      end else begin
        ready_count <= ready_count + 1'b1;
      end
    end
  end

  // ==========================================================
  // Primary alarm flags
  for (genvar c = 0; c < ALARM_COUNT; c++) begin : g_rail
    fmcsr_flag #(
      .USE_LIMITS (1'b1),
      .SIGNED_CMP (c >= FIRST_TEMP_CHANNEL)
    ) u_flag (
      .clock        (clock),
      .reset        (reset),
      .value        (monitor_value[c]),
      .high_limit   (monitor_high[c]),
      .low_limit    (monitor_low[c]),
      .set_event    (1'b0),
      .still_active (1'b0),
      .read_clear   (rd_primary),
      .flag         (rail_flag[c])
    );
  end

  // ==========================================================
  // Secondary alarm flags
  wire [2:0] fan_pwm_on;
  for (genvar f = 0; f < 3; f++) begin : g_fan_on
    assign fan_pwm_on[f] = (pwm_duty[f] != DUTY_OFF);
  end

  // Fan and diode flags plus overheat share one cell type
  wire [5:0] sec_set = {diode_fault,
                        fan_stall[2:0] & fan_pwm_on,
                        overtemp_signal};
  wire [5:0] sec_hold = {diode_fault,
                         fan_stall[2:0] & fan_pwm_on,
                         !overtemp_hysteresis};
  wire [5:0] sec_flag;
  for (genvar s = 0; s < 6; s++) begin : g_sec
    fmcsr_flag #(
      .USE_LIMITS (1'b0),
      .SIGNED_CMP (1'b0)
    ) u_flag (
      .clock        (clock),
      .reset        (reset),
      .value        (8'h00),
      .high_limit   (8'h00),
      .low_limit    (8'h00),
      .set_event    (sec_set[s]),
      .still_active (sec_hold[s]),
      .read_clear   (rd_secondary),
      .flag         (sec_flag[s])
    );
  end
  assign overheat_flag = sec_flag[0];
  assign fan_flag      = sec_flag[3:1];
  assign diode_flag    = sec_flag[5:4];

  // Bit 5 follows the shared pin mode
  wire timer_over = timer_mode && (overtemp_time > overtemp_time_limit);
  wire fan_four_cond = (shared_pin_mode == PIN_MODE_FAN4) &&
                       fan_stall[3] && fan_pwm_on[2];
  wire f4_cond = fan_four_cond | timer_over;
  fmcsr_flag #(
    .USE_LIMITS (1'b0),
    .SIGNED_CMP (1'b0)
  ) u_fan_four (
    .clock        (clock),
    .reset        (reset),
    .value        (8'h00),
    .high_limit   (8'h00),
    .low_limit    (8'h00),
    .set_event    (f4_cond),
    .still_active (f4_cond),
    .read_clear   (rd_secondary),
    .flag         (fan_four_flag)
  );

  // GPIO level is its own store so a mode change never corrupts alarms
  always_ff @(posedge clock) begin
    if (reset) begin
      gpio_level <= STATUS_RESET[ST2_F4P_BIT];
    end else if (wr_secondary && gpio_mode) begin
      gpio_level <= reg_wdata[ST2_F4P_BIT];
    end
  end

  // ==========================================================
  // Status assembly and read data
  wire bit_five = gpio_mode ? gpio_level : fan_four_flag;
  wire [7:0] secondary_alarm_status = {diode_flag, bit_five, fan_flag,
                                       overheat_flag, 1'b0};
  logic [7:0] primary_alarm_status;
  always_comb begin
    primary_alarm_status = STATUS_RESET;
    for (int c = 0; c < ALARM_COUNT; c++) begin
      primary_alarm_status[ST1_BIT[c]] = rail_flag[c];
    end
    primary_alarm_status[ST1_ANY_BIT] = |secondary_alarm_status;
  end

  wire [7:0] main_configuration = {vcc_five_volt_scale,
                                   bus_timeout_enable, spinup_bypass,
                                   power_display_flag, full_fan_override,
                                   device_ready, config_locked,
                                   monitor_run};
  wire [7:0] read_value =
    (reg_addr == ADDR_PWM_ONE_CEIL)    ? duty_ceiling[0] :
    (reg_addr == ADDR_PWM_TWO_CEIL)    ? duty_ceiling[1] :
    (reg_addr == ADDR_PWM_THREE_CEIL)  ? duty_ceiling[2] :
    (reg_addr == ADDR_MAIN_CFG)        ? main_configuration :
    (reg_addr == ADDR_PRIMARY_ALARM)   ? primary_alarm_status :
    (reg_addr == ADDR_SECONDARY_ALARM) ? secondary_alarm_status :
                                         READ_NONE;

  // Read data is the value before the clear-on-read takes effect
  always_ff @(posedge clock) begin
    if (reset) begin
      reg_rdata <= READ_NONE;
    end else if (reg_read) begin
      reg_rdata <= read_value;
    end
  end

  // ==========================================================
  // Checks
  property p_duty_clamp;
    @(posedge clock) disable iff (reset)
      (pwm_duty[0] <= $past(active_ceiling[0])) &&
      (pwm_duty[1] <= $past(active_ceiling[1])) &&
      (pwm_duty[2] <= $past(active_ceiling[2]));
  endproperty
  a_duty_clamp: assert property (p_duty_clamp)
    else $error("duty above ceiling");

  property p_locked_ceiling;
    @(posedge clock) disable iff (reset)
      (config_locked && wr_ceil_one) |=> $stable(duty_ceiling[0]);
  endproperty
  a_locked_ceiling: assert property (p_locked_ceiling)
    else $error("locked ceiling changed on write");

  // Stopped means full-scale ceilings, so the request passes untouched
  property p_run_defaults;
    @(posedge clock) disable iff (reset)
      (!monitor_run && !full_fan_override) |=>
        (pwm_duty == $past(pwm_duty_request));
  endproperty
  a_run_defaults: assert property (p_run_defaults)
    else $error("default ceiling not used while stopped");

  property p_run_keeps_ceiling;
    @(posedge clock) disable iff (reset)
      (wr_cfg && !reg_wdata[CFG_RUN_BIT] && !(|wr_ceil))
        |=> $stable(duty_ceiling);
  endproperty
  a_run_keeps_ceiling: assert property (p_run_keeps_ceiling)
    else $error("stopping the monitor altered a ceiling");

  property p_run_locked;
    @(posedge clock) disable iff (reset)
      (config_locked && wr_cfg) |=> $stable(monitor_run);
  endproperty
  a_run_locked: assert property (p_run_locked)
    else $error("run bit changed after lock");

  property p_lock_sticky;
    @(posedge clock) disable iff (reset)
      config_locked |=> config_locked [*8];
  endproperty
  a_lock_sticky: assert property (p_lock_sticky)
    else $error("lock released without reset");

  property p_ready_time;
    @(posedge clock) disable iff (reset)
      (!device_ready && ready_count == READY_LAST) |=> device_ready;
  endproperty
  a_ready_time: assert property (p_ready_time)
    else $error("ready not raised at end of power-up delay");

  property p_full_speed;
    @(posedge clock) disable iff (reset)
      full_fan_override |=> (pwm_duty == $past(active_ceiling));
  endproperty
  a_full_speed: assert property (p_full_speed)
    else $error("full speed did not drive ceiling");

  property p_any_second;
    @(posedge clock) disable iff (reset)
      rd_primary |=>
        (reg_rdata[ST1_ANY_BIT] == $past(|secondary_alarm_status));
  endproperty
  a_any_second: assert property (p_any_second)
    else $error("summary bit disagrees with second status");

  property p_fan_off_quiet;
    @(posedge clock) disable iff (reset)
      $rose(fan_flag[2]) |-> $past(pwm_duty[2] != DUTY_OFF);
  endproperty
  a_fan_off_quiet: assert property (p_fan_off_quiet)
    else $error("fan flag set while its output was off");

  property p_gpio_write;
    @(posedge clock) disable iff (reset)
      (wr_secondary && gpio_mode)
        |=> (gpio_level == $past(reg_wdata[ST2_F4P_BIT]));
  endproperty
  a_gpio_write: assert property (p_gpio_write)
    else $error("gpio level not taken from write");

  c_lock_set: cover property (@(posedge clock) disable iff (reset)
    $rose(config_locked));
  c_rail_clear: cover property (@(posedge clock) disable iff (reset)
    $fell(rail_flag[0]));
  c_fan_four: cover property (@(posedge clock) disable iff (reset)
    $rose(fan_four_flag));
  c_clamped: cover property (@(posedge clock) disable iff (reset)
    pwm_duty_request[0] > active_ceiling[0]);

endmodule
`default_nettype wire

// ===== verif/fmcsr_host.sv
// Host model: drives the register port as the serial front end would.
// Assumes one clock; every request is launched just after a rising edge.
`timescale 1ns/10ps
`default_nettype none
module fmcsr_host (
  // Clock
  input  wire logic       clock,
  // Register port
  output logic      [7:0] reg_addr,
  output logic            reg_write,
  output logic      [7:0] reg_wdata,
  output logic            reg_read,
  input  wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr = 8'h00;
    reg_write = 1'b0;
    reg_wdata = 8'h00;
    reg_read = 1'b0;
  end
  // ==========================================================
  // One-cycle strobes, held through the taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

// ===== verif/tb_fmcsr_regs.sv
// Testbench for the fan monitor register bank, one task a scenario.
// Assumes the host model on the register port and a 100 MHz clock.
`timescale 1ns/10ps
`default_nettype none
module tb_fmcsr_regs;
  import fmcsr_pkg::*;
  logic                        clock, reset, ot_sig, ot_hyst;
  logic [7:0]                  ot_time, ot_lim;
  logic [ALARM_COUNT-1:0][7:0] mval, mhigh, mlow;
  logic [FAN_COUNT-1:0]        stall;
  logic [1:0]                  diode, pin_mode;
  logic [PWM_COUNT-1:0][7:0]   req;
  wire  [PWM_COUNT-1:0][7:0]   duty;
  wire  [7:0]                  reg_addr, reg_wdata, reg_rdata, cfg;
  wire                         reg_write, reg_read, gpio;
  int                          failures = 0, check_count = 0, cycles = 0;
  localparam logic [7:0] A1 = ADDR_PRIMARY_ALARM;
  localparam logic [7:0] A2 = ADDR_SECONDARY_ALARM;

  fmcsr_host host_u (.clock(clock), .reg_addr(reg_addr),
    .reg_write(reg_write), .reg_wdata(reg_wdata), .reg_read(reg_read),
    .reg_rdata(reg_rdata));
  // Short ready delay keeps the run brief
  fmcsr_regs #(.READY_DELAY(3)) dut_u (.clock(clock), .reset(reset),
    .reg_addr(reg_addr), .reg_write(reg_write), .reg_wdata(reg_wdata),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .monitor_value(mval),
    .monitor_high(mhigh), .monitor_low(mlow), .overtemp_signal(ot_sig),
    .overtemp_hysteresis(ot_hyst), .fan_stall(stall), .diode_fault(diode),
    .shared_pin_mode(pin_mode), .overtemp_time(ot_time),
    .overtemp_time_limit(ot_lim), .pwm_duty_request(req), .pwm_duty(duty),
    .monitor_run(cfg[0]), .config_locked(cfg[1]), .device_ready(cfg[2]),
    .full_fan_override(cfg[3]), .power_display_flag(cfg[4]),
    .spinup_bypass(cfg[5]), .bus_timeout_enable(cfg[6]),
    .vcc_five_volt_scale(cfg[7]), .gpio_level(gpio));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Hang guard: far above the roughly 120 cycles the scenarios need
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failures++;
      results();
    end
  end
  // ==========================================================
  // Shared tasks
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host_u.rd(a, d);
    chk($sformatf("reg %h", a), e, d);
  endtask
  task automatic settle();
    repeat (2) @(posedge clock);
    #1;
  endtask
  task automatic results();
    $display("failures %0d checks %0d", failures, check_count);
    if (failures == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset();
    chk("cfg pins", 8'h01, cfg);
    rchk(ADDR_PWM_ONE_CEIL, 8'hFF);
    rchk(ADDR_PWM_THREE_CEIL, 8'hFF);
    host_u.wr(ADDR_MAIN_CFG, 8'h01);
    rchk(ADDR_MAIN_CFG, 8'h05);
    rchk(8'h10, 8'h00);
  endtask
  task automatic t_clamp();
    host_u.wr(ADDR_PWM_ONE_CEIL, 8'h40);
    @(posedge clock);
    req[0] <= 8'h80;
    settle();
    chk("duty0", 8'h40, duty[0]);
    host_u.wr(ADDR_MAIN_CFG, 8'hD0);
    settle();
    chk("duty0", 8'h80, duty[0]);
    rchk(ADDR_PWM_ONE_CEIL, 8'h40);
    host_u.wr(ADDR_MAIN_CFG, 8'hD1);
    rchk(ADDR_MAIN_CFG, 8'hD5);
    chk("cfg pins", 8'hD5, cfg);
  endtask
  task automatic t_lock();
    host_u.wr(ADDR_MAIN_CFG, 8'hD3);
    host_u.wr(ADDR_PWM_ONE_CEIL, 8'h11);
    host_u.wr(ADDR_MAIN_CFG, 8'h28);
    rchk(ADDR_PWM_ONE_CEIL, 8'h40);
    rchk(ADDR_MAIN_CFG, 8'hFF);
    @(posedge clock);
    req[0] <= 8'h10;
    settle();
    chk("duty0", 8'h40, duty[0]);
    host_u.wr(ADDR_MAIN_CFG, 8'h00);
    rchk(ADDR_MAIN_CFG, 8'hD7);
  endtask
  task automatic t_limits();
    @(posedge clock);
    mval[0] <= 8'h21;
    settle();
    rchk(A1, 8'h02);
    rchk(A1, 8'h02);
    @(posedge clock);
    mval[0] <= 8'h20;
    mval[3] <= 8'h00;
    settle();
    rchk(A1, 8'h22);
    rchk(A1, 8'h20);
    @(posedge clock);
    mval[3] <= 8'h10;
    rchk(A1, 8'h20);
    rchk(A1, 8'h00);
  endtask
  task automatic t_faults();
    @(posedge clock);
    req[2] <= 8'h30;
    stall <= 4'b0110;
    diode <= 2'b10;
    ot_sig <= 1'b1;
    ot_hyst <= 1'b0;
    settle();
    rchk(A1, 8'h80);
    @(posedge clock);
    stall <= 4'h0;
    diode <= 2'b00;
    ot_sig <= 1'b0;
    rchk(A2, 8'h92);
    rchk(A2, 8'h02);
    @(posedge clock);
    ot_hyst <= 1'b1;
    rchk(A2, 8'h02);
    rchk(A2, 8'h00);
    rchk(A1, 8'h00);
  endtask
  task automatic t_pin();
    @(posedge clock);
    pin_mode <= PIN_MODE_GPIO;
    host_u.wr(A2, 8'h20);
    rchk(A2, 8'h20);
    chk("gpio", 8'h01, {7'h00, gpio});
    @(posedge clock);
    pin_mode <= PIN_MODE_TIMER;
    ot_time <= 8'h05;
    ot_lim <= 8'h04;
    settle();
    rchk(A2, 8'h20);
    @(posedge clock);
    ot_time <= 8'h04;
    rchk(A2, 8'h20);
    rchk(A2, 8'h00);
    @(posedge clock);
    pin_mode <= PIN_MODE_FAN4;
    req[2] <= 8'h00;
    settle();
    @(posedge clock);
    stall <= 4'h8;
    settle();
    rchk(A2, 8'h00);
    @(posedge clock);
    req[2] <= 8'h30;
    settle();
    rchk(A2, 8'h20);
    @(posedge clock);
    stall <= 4'h0;
    rchk(A2, 8'h20);
    rchk(A2, 8'h00);
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    reset = 1'b1;
    {ot_sig, ot_time, ot_lim, pin_mode, stall, diode} = '0;
    ot_hyst = 1'b1;
    mval = {ALARM_COUNT{8'h10}};
    mhigh = {ALARM_COUNT{8'h20}};
    mlow = '0;
    req = '0;
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    #1;
    t_reset();
    t_clamp();
    t_lock();
    t_limits();
    t_faults();
    t_pin();
    results();
  end
endmodule
`default_nettype wire
